// *** core/ctw_timer.sv ***
// Core timer with overflow, periodic interrupt and watchdog behind an AHB-Lite slave
`include "ctw_params.svh"
`default_nettype none
module ctw_timer
    import ctw_pkg::*;
#(
    parameter bit WATCHDOG_PRESENT = 1'b1,
    parameter bit STOP_ENABLED = 1'b1,
    parameter int POR_CYCLES = `CTW_POR_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq_req,
    input wire logic cpu_wait,
    output logic cpu_wake,
    input wire logic stop_exec,
    output logic stop_enter,
    output logic sys_reset_n,
    input wire logic reset_pin_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // True when all chain bits up to and including top are ones
    function automatic logic chain_carry(input logic [`CTW_CHAIN_W-1:0] chain, input int top);
        logic res;
        res = 1'b1;
        for (int i = 0; i < `CTW_CHAIN_W; i++) begin
            if (i <= top) begin
                res = res & chain[i];
            end
        end
        return res;
    endfunction : chain_carry

    function automatic ctw_sel_type reg_decode(input logic [31:0] addr);
        ctw_sel_type sel;
        sel = CTW_SEL_NONE;
        if (addr[31:16] == 16'h0000 && addr[1:0] == 2'h0) begin
            case (addr[15:2])
                `CTW_IDX_CTRL_STATUS: sel = CTW_SEL_CTRL;
                `CTW_IDX_COUNT: sel = CTW_SEL_COUNT;
                `CTW_IDX_WDOG_SERVICE: sel = CTW_SEL_WDOG;
                default: sel = CTW_SEL_NONE;
            endcase
        end
        return sel;
    endfunction : reg_decode

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    ctw_state_type state_reg;
    logic [12:0] por_cnt_reg;
    logic [2:0] pulse_cnt_reg;
    logic [`CTW_CHAIN_W-1:0] chain_reg;
    logic [`CTW_WDOG_W-1:0] wdog_reg;
    ctw_ctrl_type ctrl_reg;
    ctw_flags_type flags_reg;
    logic wr_pend_reg;
    logic rd_pend_reg;
    ctw_sel_type sel_reg;
    logic hreadyout_reg;
    logic [31:0] hrdata_reg;
    logic irq_reg;
    logic wake_reg;
    logic stop_reg;
    logic sys_reset_n_reg;
    logic reset_oe_n_reg;

    logic addr_phase;
    logic ext_reset;
    logic dev_clear;
    logic chain_clear;
    logic prescale_tick;
    logic ovf_tick;
    logic tap_tick;
    logic wdog_timeout;
    logic ctrl_write;
    logic wdog_service;
    logic por_done;
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    logic [7:0] ctrl_rd;

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencing

    assign ext_reset = ~reset_pin_in;
    assign por_done = (por_cnt_reg == 13'(POR_CYCLES - 1));
    // Device logic is held clear during power-on, external and watchdog reset
    assign dev_clear = (state_reg != CTW_ST_RUN) | ext_reset;
    // Chain runs during power-on and is cleared once more when it ends
    assign chain_clear = (state_reg == CTW_ST_POR && por_done)
        | (state_reg == CTW_ST_WDRST) | (state_reg == CTW_ST_RUN && ext_reset);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= CTW_ST_POR;
            por_cnt_reg <= 13'h0000;
            pulse_cnt_reg <= 3'h0;
        end else begin
            case (state_reg)
                CTW_ST_POR: begin
                    por_cnt_reg <= por_cnt_reg + 13'h0001;
                    if (por_done) begin
                        state_reg <= CTW_ST_RUN;
                    end
                end
                CTW_ST_RUN: begin
                    if (wdog_timeout) begin
                        state_reg <= CTW_ST_WDRST;
                        pulse_cnt_reg <= 3'h0;
                    end
                end
                CTW_ST_WDRST: begin
                    pulse_cnt_reg <= pulse_cnt_reg + 3'h1;
                    if (pulse_cnt_reg == 3'(`CTW_WDOG_PULSE_CYCLES - 1)) begin
                        state_reg <= CTW_ST_RUN;
                    end
                end
                default: state_reg <= CTW_ST_POR;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sys_reset_n_reg <= 1'b0;
            reset_oe_n_reg <= 1'b1;
        end else begin
            sys_reset_n_reg <= ~dev_clear & ~(state_reg == CTW_ST_RUN && wdog_timeout);
            // Pin pulled low for the whole pulse so an emulator sees it
            reset_oe_n_reg <= ~((state_reg == CTW_ST_RUN && wdog_timeout)
                | (state_reg == CTW_ST_WDRST
                && pulse_cnt_reg != 3'(`CTW_WDOG_PULSE_CYCLES - 1)));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Timer chain: one binary counter, each divider stage is a carry enable

    assign prescale_tick = chain_carry(chain_reg, `CTW_PRESCALE_W - 1);
    assign ovf_tick = chain_carry(chain_reg, `CTW_OVF_TOP);
    // Tap picks how many of the periodic stages must carry
    assign tap_tick = chain_carry(chain_reg, `CTW_PER_BASE_TOP + int'(ctrl_reg.rate));

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chain_reg <= '0;
        end else if (chain_clear) begin
            chain_reg <= '0;
        end else begin
            // No gating by wait mode: chain always advances
            chain_reg <= chain_reg + `CTW_CHAIN_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog final stage

    assign wdog_timeout = WATCHDOG_PRESENT && tap_tick && (wdog_reg == 3'h7);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wdog_reg <= 3'h0;
        end else if (chain_clear || wdog_service) begin
            // Service clears only this stage, the chain keeps its phase
            wdog_reg <= 3'h0;
        end else if (tap_tick) begin
            // No enable input: it cannot be stopped by software or wait mode
            wdog_reg <= wdog_reg + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: writes zero wait, reads one wait so the preceding write is seen

    assign addr_phase = hsel && hready && htrans[1];
    assign ctrl_write = wr_pend_reg && (sel_reg == CTW_SEL_CTRL);
    assign wdog_service = wr_pend_reg && (sel_reg == CTW_SEL_WDOG)
        && !hwdata[`CTW_BIT_WDOG_SERVICE];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            sel_reg <= CTW_SEL_NONE;
            hreadyout_reg <= 1'b1;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            rd_pend_reg <= addr_phase && !hwrite;
            hreadyout_reg <= !(addr_phase && !hwrite);
            if (addr_phase) begin
                sel_reg <= reg_decode(haddr);
            end
        end
    end

    always_comb begin
        ctrl_rd = 8'h00;
        ctrl_rd[`CTW_BIT_OVF_FLAG] = flags_reg.ovf;
        ctrl_rd[`CTW_BIT_PER_FLAG] = flags_reg.per;
        ctrl_rd[`CTW_BIT_OVF_EN] = ctrl_reg.ovf_en;
        ctrl_rd[`CTW_BIT_PER_EN] = ctrl_reg.per_en;
        ctrl_rd[`CTW_BIT_RATE_HI:`CTW_BIT_RATE_LO] = ctrl_reg.rate;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (rd_pend_reg) begin
            case (sel_reg)
                CTW_SEL_CTRL: hrdata_reg <= {24'h00_0000, ctrl_rd};
                CTW_SEL_COUNT: hrdata_reg <= {24'h00_0000,
                    chain_reg[`CTW_OVF_TOP:`CTW_COUNT_LSB]};
                default: hrdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control bits and flags

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= '{ovf_en: 1'b0, per_en: 1'b0, rate: `CTW_RATE_RESET};
        end else if (dev_clear) begin
            ctrl_reg <= '{ovf_en: 1'b0, per_en: 1'b0, rate: `CTW_RATE_RESET};
        end else if (ctrl_write) begin
            ctrl_reg.ovf_en <= hwdata[`CTW_BIT_OVF_EN];
            ctrl_reg.per_en <= hwdata[`CTW_BIT_PER_EN];
            ctrl_reg.rate <= hwdata[`CTW_BIT_RATE_HI:`CTW_BIT_RATE_LO];
        end
    end

    assign flag_set = {ovf_tick, tap_tick};
    assign flag_clr = {ctrl_write && hwdata[`CTW_BIT_OVF_CLR],
        ctrl_write && hwdata[`CTW_BIT_PER_CLR]};

    // Flag bits written by software are ignored; a set in the clearing cycle wins
    for (genvar g = 0; g < 2; g++) begin : g_flag
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                flags_reg[g] <= 1'b0;
            end else if (dev_clear) begin
                flags_reg[g] <= 1'b0;
            end else if (flag_set[g]) begin
                flags_reg[g] <= 1'b1;
            end else if (flag_clr[g]) begin
                flags_reg[g] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // CPU side requests

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            stop_reg <= 1'b0;
        end else begin
            irq_reg <= (flags_reg.ovf & ctrl_reg.ovf_en) | (flags_reg.per & ctrl_reg.per_en);
            wake_reg <= cpu_wait & ((flags_reg.ovf & ctrl_reg.ovf_en)
                | (flags_reg.per & ctrl_reg.per_en));
            // With stop disabled the instruction simply does nothing
            stop_reg <= stop_exec & STOP_ENABLED;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign irq_req = irq_reg;
    assign cpu_wake = wake_reg;
    assign stop_enter = stop_reg;
    assign sys_reset_n = sys_reset_n_reg;
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_n = reset_oe_n_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // A chain clear restarts the divider phase, so only clear-free windows are timed
    chk_prescale_rate: assert property ((prescale_tick && !chain_clear)
        ##1 (!chain_clear) [*3]
        |=> prescale_tick && !$past(prescale_tick) && !$past(prescale_tick, 2)
        && !$past(prescale_tick, 3))
        else $error("prescaler tick not every four cycles");

    chk_count_read: assert property (rd_pend_reg && sel_reg == CTW_SEL_COUNT
        |=> hrdata[7:0] == $past(chain_reg[`CTW_OVF_TOP:`CTW_COUNT_LSB]))
        else $error("counter read does not return the count");

    chk_ovf_wrap: assert property (chain_reg[`CTW_OVF_TOP:`CTW_COUNT_LSB] == 8'hff
        && prescale_tick && !dev_clear && !chain_clear
        |=> flags_reg.ovf && chain_reg[`CTW_OVF_TOP:`CTW_COUNT_LSB] == 8'h00)
        else $error("overflow flag not set on wrap");

    chk_ovf_clear: assert property (ctrl_write && hwdata[`CTW_BIT_OVF_CLR] && !ovf_tick
        && !dev_clear |=> !flags_reg.ovf)
        else $error("overflow clear did not clear flag");

    chk_per_hold: assert property (flags_reg.per && !dev_clear
        && !(ctrl_write && hwdata[`CTW_BIT_PER_CLR]) |=> flags_reg.per)
        else $error("periodic flag lost without clear");

    chk_per_set: assert property (tap_tick && !dev_clear |=> flags_reg.per)
        else $error("periodic flag not set on tap");

    chk_clr_reads_zero: assert property (rd_pend_reg && sel_reg == CTW_SEL_CTRL
        |=> hrdata[`CTW_BIT_OVF_CLR] == 1'b0 && hrdata[`CTW_BIT_PER_CLR] == 1'b0)
        else $error("clear bits read nonzero");

    chk_irq_level: assert property (flags_reg.ovf && ctrl_reg.ovf_en |=> irq_req)
        else $error("interrupt request missing");

    chk_per_irq: assert property (flags_reg.per && ctrl_reg.per_en |=> irq_req)
        else $error("periodic interrupt request missing");

    chk_wake_req: assert property (cpu_wait && flags_reg.per && ctrl_reg.per_en
        |=> cpu_wake)
        else $error("wake request missing");

    chk_reset_values: assert property (dev_clear |=> ctrl_reg.rate == `CTW_RATE_RESET
        && !ctrl_reg.ovf_en && !ctrl_reg.per_en && flags_reg == 2'b00)
        else $error("reset values wrong");

    chk_wdog_step: assert property (tap_tick && !chain_clear && !wdog_service
        |=> wdog_reg == $past(wdog_reg) + 3'h1)
        else $error("watchdog stage did not advance on tap");

    chk_wdog_pulse: assert property (state_reg == CTW_ST_RUN && wdog_timeout
        |=> !reset_pin_oe_n && !sys_reset_n)
        else $error("watchdog timeout did not pull reset");

    chk_service: assert property (wdog_service |=> wdog_reg == 3'h0
        && chain_reg == $past(chain_reg) + `CTW_CHAIN_W'(1) || $past(chain_clear))
        else $error("service disturbed the chain");

    chk_por_release: assert property (state_reg == CTW_ST_POR && por_done
        |=> state_reg == CTW_ST_RUN && chain_reg == '0)
        else $error("power-on release did not clear chain");

    chk_ext_clear: assert property (state_reg == CTW_ST_RUN && ext_reset
        |=> chain_reg == '0)
        else $error("external reset did not clear chain");

    chk_stop_gate: assert property (stop_exec |=> stop_enter == STOP_ENABLED)
        else $error("stop request not gated by option");

endmodule : ctw_timer
`default_nettype wire

// *** include/ctw_params.svh ***
// Register map, field positions, reset values and timing counts of the core timer
`ifndef CTW_PARAMS_SVH
`define CTW_PARAMS_SVH

// Register indices; byte address is four times the index
`define CTW_IDX_CTRL_STATUS 14'h0008
`define CTW_IDX_COUNT 14'h0009
`define CTW_IDX_WDOG_SERVICE 14'h1ff0

// Control and status field positions
`define CTW_BIT_OVF_FLAG 7
`define CTW_BIT_PER_FLAG 6
`define CTW_BIT_OVF_EN 5
`define CTW_BIT_PER_EN 4
`define CTW_BIT_OVF_CLR 3
`define CTW_BIT_PER_CLR 2
`define CTW_BIT_RATE_HI 1
`define CTW_BIT_RATE_LO 0
`define CTW_BIT_WDOG_SERVICE 0

`define CTW_RATE_RESET 2'h3

// Chain layout: prescaler, visible counter, stages up to the periodic clock, tap stages
`define CTW_CHAIN_W 17
`define CTW_PRESCALE_W 2
`define CTW_COUNT_LSB 2
`define CTW_OVF_TOP 9
`define CTW_PER_BASE_TOP 13
`define CTW_WDOG_W 3

// Power-on hold in bus cycles, watchdog reset pulse length in bus cycles
`define CTW_POR_CYCLES 4064
`define CTW_WDOG_PULSE_CYCLES 4

`endif

// *** include/ctw_pkg.sv ***
// Types shared by the core timer
`default_nettype none
package ctw_pkg;

    typedef struct packed {
        logic ovf_en;
        logic per_en;
        logic [1:0] rate;
    } ctw_ctrl_type;

    typedef struct packed {
        logic ovf;
        logic per;
    } ctw_flags_type;

    typedef enum logic [1:0] {
        CTW_SEL_NONE,
        CTW_SEL_CTRL,
        CTW_SEL_COUNT,
        CTW_SEL_WDOG
    } ctw_sel_type;

    typedef enum {
        CTW_ST_POR,
        CTW_ST_RUN,
        CTW_ST_WDRST
    } ctw_state_type;

endpackage : ctw_pkg
`default_nettype wire

// *** tb/ctw_tb.sv ***
// Self-checking bench of the core timer: register access, overflow, periodic tap, resets
`include "ctw_params.svh"
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int POR = 16;
    localparam logic [31:0] A_CTRL = {16'h0000, `CTW_IDX_CTRL_STATUS, 2'b00};
    localparam logic [31:0] A_CNT = {16'h0000, `CTW_IDX_COUNT, 2'b00};
    localparam logic [31:0] A_WDOG = {16'h0000, `CTW_IDX_WDOG_SERVICE, 2'b00};
    localparam logic [31:0] A_NONE = 32'h0000_0040;

    typedef struct packed {
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic [31:0] raddr;
        logic [31:0] mask;
        logic [31:0] exp;
    } ctw_row_type;

    // Flags run freely, so control reads are masked to the software-owned bits
    localparam ctw_row_type ROWS [7] = '{
        '{A_NONE, 32'h0000_00ff, A_CTRL, 32'h0000_003f, 32'h0000_0003},
        '{A_CTRL, 32'h0000_003c, A_CTRL, 32'h0000_003f, 32'h0000_0030},
        '{A_CTRL, 32'h0000_0001, A_CTRL, 32'h0000_003f, 32'h0000_0001},
        '{A_CTRL, 32'h0000_0002, A_CTRL, 32'h0000_003f, 32'h0000_0002},
        '{A_CTRL, 32'h0000_0000, A_CTRL, 32'h0000_003f, 32'h0000_0000},
        '{A_WDOG, 32'h0000_0000, A_NONE, 32'hffff_ffff, 32'h0000_0000},
        '{A_CNT, 32'h0000_00ff, A_CNT, 32'hffff_ff00, 32'h0000_0000}
    };

    logic hclk = 1'b0;
    logic hresetn;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq_req;
    logic cpu_wait;
    logic cpu_wake;
    logic stop_exec;
    logic stop_enter;
    logic sys_reset_n;
    logic reset_pin_in;
    logic reset_pin_out;
    logic reset_pin_oe_n;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;

    always #12.5 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    assign hready = hreadyout;

    ctw_timer #(.POR_CYCLES(POR)) ctw_timer_inst (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq_req(irq_req),
        .cpu_wait(cpu_wait), .cpu_wake(cpu_wake), .stop_exec(stop_exec),
        .stop_enter(stop_enter), .sys_reset_n(sys_reset_n), .reset_pin_in(reset_pin_in),
        .reset_pin_out(reset_pin_out), .reset_pin_oe_n(reset_pin_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task conclude;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : conclude

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // One single transfer; the wait loops ride out the read wait state and guard against a stuck hreadyout
    task bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
             output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= addr;
        hwrite <= wr;
        htrans <= 2'h2;
        hsize <= 3'h2;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= wdata;
        do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
        rdata = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
        check("bus wait", {31'h0, n >= 50}, 32'h0);
    endtask : bus

    task wr(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] d;
        bus(1'b1, addr, data, d);
    endtask : wr

    task rd(input logic [31:0] addr, output logic [31:0] data);
        bus(1'b0, addr, 32'h0, data);
    endtask : rd

    // Rising edge of irq_req, cycle number returned for interval checks
    task wait_irq(output int t);
        int n;
        n = 0;
        while (irq_req !== 1'b0 && n < 40000) begin @(posedge hclk); n++; end
        while (irq_req !== 1'b1 && n < 40000) begin @(posedge hclk); n++; end
        check("irq wait", {31'h0, n >= 40000}, 32'h0);
        t = cyc;
    endtask : wait_irq

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge hclk) begin
        if (cyc > 100000) begin
            failures++;
            $display("unexpected run length expected 100000 seen %0d", cyc);
            conclude();
        end
    end

    initial begin
        logic [31:0] a;
        logic [31:0] b;
        logic [7:0] d8;
        int t1;
        int t2;
        int n;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        cpu_wait = 1'b0;
        stop_exec = 1'b0;
        reset_pin_in = 1'b1;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        n = 0;
        do begin @(posedge hclk); n++; end while (sys_reset_n !== 1'b1 && n < 1000);
        check("por length", {31'h0, n >= POR && n <= POR + 3}, 32'h1);
        $display("test power-on done");

        for (int i = 0; i < 7; i++) begin
            // Rows may move the tap, so the watchdog is serviced first
            wr(A_WDOG, 32'h0000_0000);
            wr(ROWS[i].waddr, ROWS[i].wdata);
            rd(ROWS[i].raddr, a);
            check("row read", a & ROWS[i].mask, ROWS[i].exp);
        end
        $display("test register table done");

        // Count sampled 400 cycles apart across an ignored write
        rd(A_CNT, a);
        t1 = cyc;
        wr(A_CNT, 32'h0000_0000);
        while (cyc < t1 + 396) @(posedge hclk);
        rd(A_CNT, b);
        d8 = b[7:0] - a[7:0];
        check("count step", {24'h0, d8}, 32'h0000_0064);
        $display("test counter done");

        wr(A_CTRL, 32'h0000_0028);
        wait_irq(t1);
        rd(A_CTRL, a);
        check("ovf flag set", {31'h0, a[7]}, 32'h1);
        wr(A_CTRL, 32'h0000_00a0);
        rd(A_CTRL, a);
        check("ovf clear zero", {31'h0, a[7]}, 32'h1);
        wr(A_CTRL, 32'h0000_0028);
        rd(A_CTRL, a);
        check("ovf clear one", {31'h0, a[7]}, 32'h0);
        wait_irq(t2);
        check("ovf period", 32'(t2 - t1), 32'd1024);
        wr(A_CTRL, 32'h0000_0000);
        repeat (3) @(posedge hclk);
        check("irq masked", {31'h0, irq_req}, 32'h0);
        $display("test overflow done");

        cpu_wait <= 1'b1;
        wr(A_CTRL, 32'h0000_0014);
        wait_irq(t1);
        repeat (2) @(posedge hclk);
        check("cpu wake", {31'h0, cpu_wake}, 32'h1);
        rd(A_CTRL, a);
        check("per flag set", {31'h0, a[6]}, 32'h1);
        wr(A_CTRL, 32'h0000_0014);
        rd(A_CTRL, a);
        check("per flag clear", {31'h0, a[6]}, 32'h0);
        wr(A_WDOG, 32'h0000_0000);
        wait_irq(t2);
        check("per period", 32'(t2 - t1), 32'd16384);
        cpu_wait <= 1'b0;
        repeat (3) @(posedge hclk);
        check("cpu awake", {31'h0, cpu_wake}, 32'h0);
        $display("test periodic done");

        stop_exec <= 1'b1;
        repeat (3) @(posedge hclk);
        check("stop enter", {31'h0, stop_enter}, 32'h1);
        stop_exec <= 1'b0;
        reset_pin_in <= 1'b0;
        repeat (3) @(posedge hclk);
        check("ext reset", {31'h0, sys_reset_n}, 32'h0);
        reset_pin_in <= 1'b1;
        n = 0;
        do begin @(posedge hclk); n++; end while (sys_reset_n !== 1'b1 && n < 1000);
        rd(A_CNT, a);
        check("count restart", {31'h0, a[7:0] <= 8'h03}, 32'h1);
        rd(A_CTRL, a);
        check("ctrl after reset", a & 32'h0000_00ff, 32'h0000_0003);
        check("pin released", {31'h0, reset_pin_oe_n}, 32'h1);
        check("pin level", {31'h0, reset_pin_out}, 32'h0);
        $display("test resets done");
        conclude();
    end
endmodule : testbench
`default_nettype wire
